// ==== bench/lccm_mcu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Controller model: SPI master, mode 0, 16-bit frames, MSB first
module lccm_mcu_model (
  input wire logic sys_clk,
  output logic spiCsB,
  output logic spiSclk,
  output logic spiMosi,
  input wire logic spiMisoOut
);
  // Idle bus: deselected, clock low
  initial begin
    spiCsB = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end
  // One frame; every change lands on a falling system clock edge
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rdData);
    @(negedge sys_clk);
    spiCsB = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spiMosi = frame[i];
      repeat (4) @(negedge sys_clk);
      spiSclk = 1'b1;
      // Data bits are sampled on the rising clock
      if (i < 8) rdData[i] = spiMisoOut;
      repeat (4) @(negedge sys_clk);
      spiSclk = 1'b0;
    end
    // Idle data line shows no stale bit
    spiMosi = ~spiMosi;
    repeat (4) @(negedge sys_clk);
    spiCsB = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule // lccm_mcu_model
`default_nettype wire

// ==== bench/lccm_top_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the LED channel control core
module lccm_top_checker #(
  parameter OC_HOLD_CYC = 20,
  parameter MEAS_PER_CYC = 8,
  parameter STATIC_CYC = 50
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [2:0] dimIn,
  input wire [2:0] ocDetect,
  input wire [2:0] switchReq,
  input wire measValid,
  input wire [23:0] measCode,
  input wire errPresent,
  input wire spiCsB,
  input wire spiSclk,
  input wire spiMosi,
  input wire spiMisoOut,
  input wire spiMisoOeB,
  input wire [2:0] gateDriveOut,
  input wire [2:0] ocHoldActive,
  input wire measReq,
  input wire errClearReq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  reg [31:0] holdCnt_ff; // Hold-off cycles seen on channel one
  reg [31:0] nxt_holdCnt; // Next hold-off count
  // Count restarts on each overcurrent event
  always @* begin
    nxt_holdCnt = 32'h00000000;
    if (!ocDetect[0] && ocHoldActive[0]) nxt_holdCnt = holdCnt_ff + 32'h00000001;
  end
  // Counter register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) holdCnt_ff <= 32'h00000000;
    else holdCnt_ff <= nxt_holdCnt;
  end
  sequence measGap; !measReq [*7]; endsequence
  dimOff_a: assert property ((gateDriveOut & ~$past(dimIn)) == 3'h0)
    else $error("gate on with dimming low");
  gateCause_a: assert property ((gateDriveOut & (~$past(switchReq) | $past(ocDetect))) == 3'h0)
    else $error("gate on without request");
  ocOff_a: assert property (|ocDetect |=> (gateDriveOut & $past(ocDetect)) == 3'h0
    && (ocHoldActive & $past(ocDetect)) == $past(ocDetect)) else $error("overcurrent not stopped");
  holdLen_a: assert property ($fell(ocHoldActive[0]) |-> holdCnt_ff == OC_HOLD_CYC)
    else $error("hold-off length wrong");
  holdBound_a: assert property (holdCnt_ff <= OC_HOLD_CYC)
    else $error("hold-off too long");
  misoOe_a: assert property (spiMisoOeB == spiCsB)
    else $error("data out enable wrong");
  holdGate_a: assert property ((gateDriveOut & $past(ocHoldActive)) == 3'h0)
    else $error("gate on during hold-off");
  measPeriod_a: assert property (measReq |=> measGap ##1 measReq)
    else $error("sample period wrong");
  clrErr_a: assert property (!errPresent |=> !errClearReq)
    else $error("clear without error");
endmodule // lccm_top_checker
bind lccm_top lccm_top_checker #(.OC_HOLD_CYC(OC_HOLD_CYC), .MEAS_PER_CYC(MEAS_PER_CYC),
  .STATIC_CYC(STATIC_CYC)) u_lccm_top_checker (.sys_clk(sys_clk), .rst_b(rst_b),
  .dimIn(dimIn), .ocDetect(ocDetect), .switchReq(switchReq), .measValid(measValid),
  .measCode(measCode), .errPresent(errPresent), .spiCsB(spiCsB), .spiSclk(spiSclk),
  .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOeB(spiMisoOeB),
  .gateDriveOut(gateDriveOut), .ocHoldActive(ocHoldActive), .measReq(measReq),
  .errClearReq(errClearReq));
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("mismatch at %0t: %s", $time, m); end end
// Self-checking bench for the LED channel control core
module testbench;
  logic sys_clk = 1'b0; // System clock
  logic rst_b = 1'b0; // Reset, active low
  logic [2:0] dimIn = 3'h0; // Dimming pins
  logic [2:0] ocDetect = 3'h0; // Overcurrent events
  logic [2:0] switchReq = 3'h0; // Comparator requests
  logic measValid = 1'b0; // Converter result strobe
  logic measOn = 1'b1; // Converter running
  logic [23:0] measCode = 24'h000000; // Converter codes
  logic errPresent = 1'b0; // Error bits pending
  wire spiCsB, spiSclk, spiMosi, spiMisoOut, spiMisoOeB, measReq, errClearReq;
  wire [2:0] gateDriveOut, ocHoldActive;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] rd; // Last read data
  logic [2:0] enTab [3] = '{3'h2, 3'h5, 3'h7}; // Enable patterns
  always #4 sys_clk = ~sys_clk;
  // Converter answers each sample request half a cycle later while running
  always @(negedge sys_clk) measValid <= measReq & measOn;
  lccm_top #(.OC_HOLD_CYC(20), .MEAS_PER_CYC(8), .STATIC_CYC(50)) u_lccm_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .dimIn(dimIn), .ocDetect(ocDetect),
    .switchReq(switchReq), .measValid(measValid), .measCode(measCode),
    .errPresent(errPresent), .spiCsB(spiCsB), .spiSclk(spiSclk), .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut), .spiMisoOeB(spiMisoOeB), .gateDriveOut(gateDriveOut),
    .ocHoldActive(ocHoldActive), .measReq(measReq), .errClearReq(errClearReq));
  lccm_mcu_model u_lccm_mcu_model (.sys_clk(sys_clk), .spiCsB(spiCsB),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut));
  // Register write frame
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_lccm_mcu_model.xfer({1'b1, a, d}, rd);
  endtask
  // Register read frame with comparison
  task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string m);
    u_lccm_mcu_model.xfer({1'b0, a, 8'h00}, rd);
    `CHK(rd, e, m)
  endtask
  // Wait whole cycles
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Read all six results in address order
  task automatic chkRes(input logic [23:0] onV, input logic [23:0] offV);
    for (int c = 0; c < 3; c++) begin
      rdc(7'h20 + 7'(2 * c), onV[8 * c +: 8], "on result");
      rdc(7'h21 + 7'(2 * c), offV[8 * c +: 8], "off result");
    end
  endtask
  // Main sequence
  initial begin
    cyc(12);
    rst_b = 1'b1;
    cyc(3);
    rdc(7'h00, 8'h00, "control reset");
    `CHK(spiMisoOeB, 1'b1, "miso released")
    chkRes(24'h000000, 24'h000000);
    wr(7'h00, 8'h80);
    rdc(7'h00, 8'h80, "ready readback");
    wr(7'h00, 8'hCE);
    rdc(7'h00, 8'hCE, "clear waits");
    errPresent = 1'b1;
    cyc(3);
    `CHK(errClearReq, 1'b1, "clear request")
    errPresent = 1'b0;
    cyc(3);
    `CHK(errClearReq, 1'b0, "clear released")
    rdc(7'h00, 8'h8E, "clear self-cleared");
    rdc(7'h30, 8'h00, "unmapped read");
    wr(7'h20, 8'h55);
    rdc(7'h20, 8'h00, "read-only result");
    foreach (enTab[k]) begin
      wr(7'h00, {4'h8, enTab[k], 1'b0});
      dimIn = 3'h7;
      switchReq = 3'h7;
      cyc(3);
      `CHK(gateDriveOut, enTab[k], "gate follows enable")
      switchReq = 3'h0;
      cyc(2);
      `CHK(gateDriveOut, 3'h0, "gate follows request")
      switchReq = 3'h7;
      dimIn = 3'h0;
      cyc(2);
      `CHK(gateDriveOut, 3'h0, "gate off when dim low")
    end
    dimIn = 3'h7;
    cyc(3);
    ocDetect = 3'h1;
    cyc(1);
    ocDetect = 3'h0;
    `CHK({ocHoldActive[0], gateDriveOut[0]}, 2'h2, "overcurrent stop")
    cyc(18);
    `CHK(ocHoldActive[0], 1'b1, "hold-off running")
    cyc(3);
    `CHK(gateDriveOut, 3'h7, "restart after hold-off")
    ocDetect = 3'h2;
    cyc(1);
    ocDetect = 3'h0;
    dimIn = 3'h5;
    cyc(25);
    `CHK(gateDriveOut, 3'h5, "no restart with dim low")
    dimIn = 3'h0;
    measCode = 24'h332211;
    cyc(30);
    dimIn = 3'h7;
    measCode = 24'h665544;
    cyc(30);
    measOn = 1'b0;
    cyc(2);
    dimIn = 3'h0;
    cyc(2);
    chkRes(24'h665544, 24'h332211);
    measOn = 1'b1;
    measCode = 24'h998877;
    cyc(70);
    chkRes(24'h665544, 24'h998877);
    final_report();
  end
  // Watchdog
  initial begin
    #200000;
    failures++;
    $display("mismatch at %0t: timeout", $time);
    final_report();
  end
  // Verdict and end of run
  task automatic final_report();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
endmodule // testbench
`default_nettype wire

// ==== verilog/lccm_defs.vh ====
`ifndef LCCM_DEFS_VH
`define LCCM_DEFS_VH

// Register addresses (7-bit SPI address field)
`define LCCM_ADDR_FUNC_CTRL 7'h00
`define LCCM_ADDR_CH1_ON 7'h20
`define LCCM_ADDR_CH1_OFF 7'h21
`define LCCM_ADDR_CH2_ON 7'h22
`define LCCM_ADDR_CH2_OFF 7'h23
`define LCCM_ADDR_CH3_ON 7'h24
`define LCCM_ADDR_CH3_OFF 7'h25

// Function control field positions
`define LCCM_FC_IF_READY 7
`define LCCM_FC_CLR_ERR 6
`define LCCM_FC_DIM_EN_HI 3
`define LCCM_FC_DIM_EN_LO 1

// Reset values
`define LCCM_FC_RST 8'h00
`define LCCM_VOLT_RST 8'h00
`define LCCM_VOLT_ZERO 8'h00

// SPI frame layout: write flag, 7 address bits, 8 data bits
`define LCCM_SPI_FRAME_BITS 5'h10
`define LCCM_SPI_HDR_BITS 5'h08

// Timing: clock rate and times in their own units
`define LCCM_CLK_MHZ 125
`define LCCM_OC_HOLD_MS 16
`define LCCM_MEAS_PER_US 100
`define LCCM_STATIC_MS 10
`define LCCM_OC_HOLD_CYC (`LCCM_OC_HOLD_MS * 1000 * `LCCM_CLK_MHZ)
`define LCCM_MEAS_PER_CYC (`LCCM_MEAS_PER_US * `LCCM_CLK_MHZ)
`define LCCM_STATIC_CYC (`LCCM_STATIC_MS * 1000 * `LCCM_CLK_MHZ)

`endif

// ==== verilog/lccm_spi_slave.v ====
`timescale 1ns/100ps
`default_nettype none
`include "lccm_defs.vh"

// Oversampled SPI slave, mode 0, MSB first, 16-bit frames
module lccm_spi_slave (
  input wire sys_clk,
  input wire rst_b,
  input wire spiCsB,
  input wire spiSclk,
  input wire spiMosi,
  output wire spiMisoOut,
  output wire spiMisoOeB,
  output wire [6:0] rdAddr,
  input wire [7:0] rdData,
  output reg wrStb_ff,
  output reg [6:0] wrAddr_ff,
  output reg [7:0] wrData_ff
);

  reg sclkDly_ff; // Previous serial clock level
  reg csDly_ff; // Previous select level
  reg [4:0] bitCnt_ff; // Bits taken in this frame
  reg [15:0] shIn_ff; // Incoming shift register
  reg [7:0] shOut_ff; // Outgoing shift register
  reg rdLoad_ff; // Header complete, load read data

  wire sclkRise = spiSclk & ~sclkDly_ff;
  wire sclkFall = ~spiSclk & sclkDly_ff;
  wire csStart = ~spiCsB & csDly_ff;
  wire csEnd = spiCsB & ~csDly_ff;

  // Address of a read is the seven bits after the write flag
  assign rdAddr = shIn_ff[6:0];
  // Read data leaves MSB first
  assign spiMisoOut = shOut_ff[7];
  // Output enable is low while selected
  assign spiMisoOeB = spiCsB;

  // Frame engine
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkDly_ff <= 1'b0;
      csDly_ff <= 1'b1;
      bitCnt_ff <= 5'h00;
      shIn_ff <= 16'h0000;
      shOut_ff <= 8'h00;
      rdLoad_ff <= 1'b0;
      wrStb_ff <= 1'b0;
      wrAddr_ff <= 7'h00;
      wrData_ff <= 8'h00;
    end else begin
      sclkDly_ff <= spiSclk;
      csDly_ff <= spiCsB;
      wrStb_ff <= 1'b0;
      rdLoad_ff <= 1'b0;
      if (csStart) begin
        // New frame
        bitCnt_ff <= 5'h00;
        shOut_ff <= 8'h00;
      end else if (csEnd) begin
        // Only whole write frames take effect, others are dropped
        if ((bitCnt_ff == `LCCM_SPI_FRAME_BITS) && shIn_ff[15]) begin
          wrStb_ff <= 1'b1;
          wrAddr_ff <= shIn_ff[14:8];
          wrData_ff <= shIn_ff[7:0];
        end
      end else if (!spiCsB) begin
        if (sclkRise) begin
          shIn_ff <= {shIn_ff[14:0], spiMosi};
          if (bitCnt_ff != 5'h1F) begin
            bitCnt_ff <= bitCnt_ff + 5'h01;
          end
          if (bitCnt_ff == (`LCCM_SPI_HDR_BITS - 5'h01)) begin
            rdLoad_ff <= 1'b1;
          end
        end else if (rdLoad_ff) begin
          // Header in, fetch the addressed register
          shOut_ff <= rdData;
        end else if (sclkFall && (bitCnt_ff > `LCCM_SPI_HDR_BITS)) begin
          shOut_ff <= {shOut_ff[6:0], 1'b0};
        end
      end
    end
  end

endmodule // lccm_spi_slave

`default_nettype wire

// ==== verilog/lccm_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "lccm_defs.vh"

// Digital control and measurement core of a three-channel LED driver
module lccm_top #(
  parameter OC_HOLD_CYC = `LCCM_OC_HOLD_CYC,
  parameter MEAS_PER_CYC = `LCCM_MEAS_PER_CYC,
  parameter STATIC_CYC = `LCCM_STATIC_CYC
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [2:0] dimIn,
  input wire [2:0] ocDetect,
  input wire [2:0] switchReq,
  input wire measValid,
  input wire [23:0] measCode,
  input wire errPresent,
  input wire spiCsB,
  input wire spiSclk,
  input wire spiMosi,
  output wire spiMisoOut,
  output wire spiMisoOeB,
  output wire [2:0] gateDriveOut,
  output wire [2:0] ocHoldActive,
  output wire measReq,
  output wire errClearReq
);

  // Counter reload values, worked out at full width first
  localparam [31:0] OC_LOAD_W = OC_HOLD_CYC - 1;
  localparam [31:0] STATIC_LAST_W = STATIC_CYC - 1;
  localparam [31:0] MEAS_LAST_W = MEAS_PER_CYC - 1;
  // Counters are 22 bits wide, enough for the longest default span
  localparam [21:0] OC_LOAD = OC_LOAD_W[21:0];
  localparam [21:0] STATIC_LAST = STATIC_LAST_W[21:0];
  localparam [21:0] MEAS_LAST = MEAS_LAST_W[21:0];

  // Register bus signals
  // Write strobe is one cycle wide; reads are combinational
  wire [6:0] rdAddr; // Address of the current read
  reg [7:0] rdData; // Data returned for that address
  wire wrStb; // One-cycle write pulse
  wire [6:0] wrAddr; // Write address
  wire [7:0] wrData; // Write data
  wire fcWrite; // Write to function control

  // Function control register fields
  reg ifReady_ff; // Interface-ready flag
  reg clrError_ff; // Pending error-clear request
  reg errSeen_ff; // Error met while request pending
  reg clrPulse_ff; // Clear command towards error logic
  reg [2:0] dimEnable_ff; // Per-channel dimming enable
  wire [7:0] fcReadVal; // Read view of function control

  // Measurement timing
  reg [21:0] measCnt_ff; // Measurement period counter
  reg measReq_ff; // Sample request pulse

  // Per-channel result buses for the read mux
  wire [23:0] onVoltBus; // On-state results, channel 1 low
  wire [23:0] offVoltBus; // Off-state results, channel 1 low

  // Serial interface shifter
  // Frames are checked there; only whole writes reach the registers
  lccm_spi_slave uSpi (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .spiCsB(spiCsB),
    .spiSclk(spiSclk),
    .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut),
    .spiMisoOeB(spiMisoOeB),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .wrStb_ff(wrStb),
    .wrAddr_ff(wrAddr),
    .wrData_ff(wrData)
  );

  // Write strobe aimed at the function control register
  // A cut frame raises no strobe, so it changes nothing here
  assign fcWrite = wrStb && (wrAddr == `LCCM_ADDR_FUNC_CTRL);

  // Reserved bits 5:4 and 0 always read as zero
  // Ready and clear flags on top, enables in bits 3:1
  assign fcReadVal = {ifReady_ff, clrError_ff, 2'b00, dimEnable_ff, 1'b0};

  // Read decode; unmapped addresses return zero
  // Combinational so the byte is ready the cycle after the header ends
  always @* begin
    if (rdAddr == `LCCM_ADDR_FUNC_CTRL) begin
      rdData = fcReadVal;
    end else if (rdAddr == `LCCM_ADDR_CH1_ON) begin
      rdData = onVoltBus[7:0];
    end else if (rdAddr == `LCCM_ADDR_CH1_OFF) begin
      rdData = offVoltBus[7:0];
    end else if (rdAddr == `LCCM_ADDR_CH2_ON) begin
      rdData = onVoltBus[15:8];
    end else if (rdAddr == `LCCM_ADDR_CH2_OFF) begin
      rdData = offVoltBus[15:8];
    end else if (rdAddr == `LCCM_ADDR_CH3_ON) begin
      rdData = onVoltBus[23:16];
    end else if (rdAddr == `LCCM_ADDR_CH3_OFF) begin
      rdData = offVoltBus[23:16];
    end else begin
      // Nothing mapped here
      rdData = 8'h00;
    end
  end

  // Interface-ready flag, as last written by the controller
  // Each completed write to this register loads bit 7 into the flag,
  // so a later write with bit 7 low clears it again
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Interface not yet proven after reset
      ifReady_ff <= 1'b0;
    end else if (fcWrite) begin
      ifReady_ff <= wrData[`LCCM_FC_IF_READY];
    end
  end

  // Per-channel dimming enables; all channels off after reset
  // Reserved bits are not stored, whatever is written
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dimEnable_ff <= 3'h0;
    end else if (fcWrite) begin
      dimEnable_ff <= wrData[`LCCM_FC_DIM_EN_HI:`LCCM_FC_DIM_EN_LO];
    end
  end

  // Error-clear request: set by a one, released once errors are gone
  // Remembers whether an error was met, so a request made with no error
  // present waits for one instead of releasing at once
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clrError_ff <= 1'b0;
      errSeen_ff <= 1'b0;
    end else if (fcWrite && wrData[`LCCM_FC_CLR_ERR]) begin
      // A new request wins over a release in the same cycle
      clrError_ff <= 1'b1;
      errSeen_ff <= errPresent;
    end else if (clrError_ff) begin
      if (errPresent) begin
        // Error met while the request is pending
        errSeen_ff <= 1'b1;
      end else if (errSeen_ff) begin
        // Errors have been cleared: release the request
        clrError_ff <= 1'b0;
        errSeen_ff <= 1'b0;
      end
    end
  end

  // Clear command towards the error logic, one cycle behind the request
  // Registered so the error logic never sees a glitch from the bus decode
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clrPulse_ff <= 1'b0;
    end else begin
      // Stands while a request meets a live error
      clrPulse_ff <= clrError_ff & errPresent;
    end
  end

  // Clear command leaves the block straight from its register
  assign errClearReq = clrPulse_ff;

  // Measurement period counter, wraps once per sample period
  // Runs from reset, so the first request comes a full period later
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      measCnt_ff <= 22'h000000;
    end else if (measCnt_ff == MEAS_LAST) begin
      // Period over, start the next one
      measCnt_ff <= 22'h000000;
    end else begin
      // Count on within the period
      measCnt_ff <= measCnt_ff + 22'h000001;
    end
  end

  // Sample request, one cycle wide at each wrap of the counter
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      measReq_ff <= 1'b0;
    end else begin
      // All three channels are sampled together
      measReq_ff <= (measCnt_ff == MEAS_LAST);
    end
  end

  // Request leaves the block straight from its register
  assign measReq = measReq_ff;

  // Channel logic, one copy per channel
  // Channels share nothing but the converter codes, the result strobe and the enables
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : gChan
      reg ocHold_ff; // Overcurrent hold-off active
      reg [21:0] holdCnt_ff; // Remaining hold-off cycles
      reg gate_ff; // Gate drive command
      reg dimDly_ff; // Previous dimming level
      reg [21:0] statCnt_ff; // Cycles since last transfer
      reg [7:0] lastOn_ff; // Latest sample with dimming high
      reg [7:0] lastOff_ff; // Latest sample with dimming low
      reg [7:0] onVolt_ff; // On-state result register
      reg [7:0] offVolt_ff; // Off-state result register
      wire dimEdge; // Any dimming transition
      wire staticDue; // Level unchanged for the static interval
      wire runOk; // All conditions to switch are met
      wire [7:0] code; // This channel's converter code

      // Edge and static checks that trigger a result transfer
      assign dimEdge = dimIn[ch] ^ dimDly_ff;
      assign staticDue = (statCnt_ff == STATIC_LAST);
      assign code = measCode[ch*8 +: 8];

      // Enable, dimming level and hold-off all gate the switching
      // The event itself blocks too, so the gate drops on the edge that sees it
      assign runOk = dimEnable_ff[ch] & dimIn[ch] & ~ocHold_ff & ~ocDetect[ch];

      // Hold-off flag: raised by an event, dropped when the count is spent
      // A new event in the last cycle wins, so a late trip is never lost
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          ocHold_ff <= 1'b0;
        end else if (ocDetect[ch]) begin
          // Event: stop the channel at once
          ocHold_ff <= 1'b1;
        end else if (ocHold_ff && (holdCnt_ff == 22'h000000)) begin
          // Hold-off over, channel restarts on its own
          ocHold_ff <= 1'b0;
        end
      end

      // Hold-off counter; a new event reloads it
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          holdCnt_ff <= 22'h000000;
        end else if (ocDetect[ch]) begin
          // Load the full hold-off span
          holdCnt_ff <= OC_LOAD;
        end else if (ocHold_ff && (holdCnt_ff != 22'h000000)) begin
          // Count down while the hold-off runs
          holdCnt_ff <= holdCnt_ff - 22'h000001;
        end
      end

      // Gate drive follows the hysteretic switch request when allowed
      // Registered, so the pin never glitches on a late request change
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          gate_ff <= 1'b0;
        end else if (runOk) begin
          // Follow the comparator while every condition holds
          gate_ff <= switchReq[ch];
        end else begin
          // Dimming low, disabled or overcurrent: transistor off
          gate_ff <= 1'b0;
        end
      end

      // Samples sorted by the dimming level they were taken at
      // Sorting keeps the on register free of off-state samples
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          lastOn_ff <= `LCCM_VOLT_RST;
          lastOff_ff <= `LCCM_VOLT_RST;
        end else if (measValid) begin
          // Code passes unchanged, zero stands for 0 V
          if (dimIn[ch]) begin
            lastOn_ff <= code;
          end else begin
            lastOff_ff <= code;
          end
        end
      end

      // Dimming level one cycle back, for edge detection
      // Resets low to match an idle pin, so no false edge follows reset
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          dimDly_ff <= 1'b0;
        end else begin
          dimDly_ff <= dimIn[ch];
        end
      end

      // Cycles since the last transfer; restarts on every transfer
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          statCnt_ff <= 22'h000000;
        end else if (dimEdge || staticDue) begin
          // Transfer this cycle, start a new static spell
          statCnt_ff <= 22'h000000;
        end else begin
          // Level unchanged, keep counting
          statCnt_ff <= statCnt_ff + 22'h000001;
        end
      end

      // Transfer to the result registers on edges or after a static spell
      // A sample arriving in the transfer cycle waits for the next one
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          onVolt_ff <= `LCCM_VOLT_RST;
          offVolt_ff <= `LCCM_VOLT_RST;
        end else if (dimEdge || staticDue) begin
          // Copy the latest sorted samples
          onVolt_ff <= lastOn_ff;
          offVolt_ff <= lastOff_ff;
        end
      end

      // Channel state onto the shared output and read buses
      assign gateDriveOut[ch] = gate_ff;
      assign ocHoldActive[ch] = ocHold_ff;
      assign onVoltBus[ch*8 +: 8] = onVolt_ff;
      assign offVoltBus[ch*8 +: 8] = offVolt_ff;
    end
  endgenerate

endmodule // lccm_top

`default_nettype wire
